/* hw/ifsl_pkg.sv */
// Package: constants for the isolated fast serial link
package ifsl_pkg;
    localparam int          DATA_BITS      = 8;
    localparam int          FRAME_BITS     = 10;
    localparam logic [3:0]  BIT_FIRST_DATA = 4'h1;
    localparam logic [3:0]  BIT_CHAN       = 4'h9;
    localparam logic [3:0]  BMODE_HOLD     = 4'h2;
    localparam logic [3:0]  BMODE_RUN      = 4'h0;
    localparam logic        LINE_IDLE      = 1'b1;
    localparam logic        START_LEVEL    = 1'b0;
endpackage

/* hw/ifsl_link.sv */
// Isolated fast serial link: device end with link clock domain
// Operation
// - Four link signals: clock, out, in, cts
// - Transmit frame starts with zero start bit
// - No transmit start while receiving a frame
// - Eight payload bits sent LSB first
// - Last sent bit gives source channel
// - Start bit seen drops cts next rising edge
// - Eight payload bits received LSB first
// - Last received bit selects destination channel
// - Unconfigured destination goes to other channel
// - Link disabled unless a channel is configured
// - Cts low until another byte can be accepted
// - Link always on second channel pins
// - Mode comes from configuration memory bits
// - Bit mode 10 holds link in reset
`timescale 1ns/1ns
`default_nettype none
module ifsl_link #(
    parameter int DATA_W = ifsl_pkg::DATA_BITS
) (
    input  wire logic              core_clk,
    input  wire logic              srst,
    input  wire logic              cfg_chan_a_serial,
    input  wire logic              cfg_chan_b_serial,
    input  wire logic [3:0]        bit_mode,
    input  wire logic              bit_mode_load,
    input  wire logic              tx_valid,
    input  wire logic [DATA_W-1:0] tx_data,
    input  wire logic              tx_chan,
    output logic                   tx_ready,
    output logic                   rx_valid,
    output logic [DATA_W-1:0]      rx_data,
    output logic                   rx_chan,
    input  wire logic              rx_ready,
    output logic                   link_enabled,
    input  wire logic              link_serial_clock,
    output logic                   link_data_out,
    input  wire logic              link_data_in,
    output logic                   link_clear_to_send
);
    // Elaboration check: the shifters serve one payload width only
    if (DATA_W != ifsl_pkg::DATA_BITS) begin : g_bad_width
        $error("DATA_W must be 8");
    end

    // Core domain: configuration and hold
    logic hold_ff;
    logic enable_ff;
    logic cfg_ok;
    assign cfg_ok = cfg_chan_a_serial | cfg_chan_b_serial;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            hold_ff <= 1'b0;
        end else if (bit_mode_load && bit_mode == ifsl_pkg::BMODE_HOLD) begin
            hold_ff <= 1'b1;
        end else if (bit_mode_load && bit_mode == ifsl_pkg::BMODE_RUN) begin
            hold_ff <= 1'b0;
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            enable_ff <= 1'b0;
        end else begin
            enable_ff <= cfg_ok & ~hold_ff;
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            link_enabled <= 1'b0;
        end else begin
            link_enabled <= enable_ff;
        end
    end

    // Cross-domain toggles, link-domain levels and byte holds
    logic en_s1_ff;
    logic en_s2_ff;
    logic srst_s1_ff;
    logic srst_s2_ff;
    logic tx_req_tgl_ff;
    logic tx_ack_tgl_ff;
    logic rx_ev_tgl_ff;
    logic rx_ack_tgl_ff;
    logic [DATA_W-1:0] tx_hold_ff;
    logic tx_chan_hold_ff;
    logic [DATA_W-1:0] rx_hold_ff;
    logic rx_chan_hold_ff;

    // Core side: transmit handshake
    logic txa_s1_ff;
    logic txa_s2_ff;
    logic rxe_s1_ff;
    logic rxe_s2_ff;
    logic rxe_s3_ff;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            txa_s1_ff <= 1'b0;
            txa_s2_ff <= 1'b0;
            rxe_s1_ff <= 1'b0;
            rxe_s2_ff <= 1'b0;
            rxe_s3_ff <= 1'b0;
        end else begin
            txa_s1_ff <= tx_ack_tgl_ff;
            txa_s2_ff <= txa_s1_ff;
            rxe_s1_ff <= rx_ev_tgl_ff;
            rxe_s2_ff <= rxe_s1_ff;
            rxe_s3_ff <= rxe_s2_ff;
        end
    end
    logic tx_idle;
    assign tx_idle = (tx_req_tgl_ff == txa_s2_ff);
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tx_req_tgl_ff   <= 1'b0;
            tx_hold_ff      <= '0;
            tx_chan_hold_ff <= 1'b0;
        end else if (tx_valid && tx_ready) begin
            tx_req_tgl_ff   <= ~tx_req_tgl_ff;
            tx_hold_ff      <= tx_data;
            tx_chan_hold_ff <= tx_chan;
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tx_ready <= 1'b0;
        end else begin
            // Host data is still taken while held; it waits in tx_hold
            tx_ready <= tx_idle && !(tx_valid && tx_ready) && cfg_ok;
        end
    end

    // Core side: receive delivery
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rx_valid <= 1'b0;
            rx_data  <= '0;
            rx_chan  <= 1'b0;
        end else if (rxe_s2_ff != rxe_s3_ff) begin
            rx_valid <= 1'b1;
            rx_data  <= rx_hold_ff;
            if (rx_chan_hold_ff && !cfg_chan_b_serial) begin
                rx_chan <= 1'b0;
            end else if (!rx_chan_hold_ff && !cfg_chan_a_serial) begin
                rx_chan <= 1'b1;
            end else begin
                rx_chan <= rx_chan_hold_ff;
            end
        end else if (rx_valid && rx_ready) begin
            rx_valid <= 1'b0;
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rx_ack_tgl_ff <= 1'b0;
        end else if (rx_valid && rx_ready) begin
            rx_ack_tgl_ff <= rxe_s3_ff; // Consumer free again
        end
    end

    // Link domain (rising edge): synchronisers and receiver
    logic txr_s1_ff;
    logic txr_s2_ff;
    logic rxa_s1_ff;
    logic rxa_s2_ff;
    logic din_s1_ff;
    logic din_s2_ff;
    always_ff @(posedge link_serial_clock) begin
        // Reset reaches the link toggles so both handshake sides start equal
        srst_s1_ff <= srst;
        srst_s2_ff <= srst_s1_ff;
        en_s1_ff  <= enable_ff;
        en_s2_ff  <= en_s1_ff;
        txr_s1_ff <= tx_req_tgl_ff;
        txr_s2_ff <= txr_s1_ff;
        rxa_s1_ff <= rx_ack_tgl_ff;
        rxa_s2_ff <= rxa_s1_ff;
        din_s1_ff <= link_data_in;
        din_s2_ff <= din_s1_ff;
    end

    typedef enum logic [1:0] {IFSL_IDLE, IFSL_SHIFT, IFSL_WAIT} ifsl_rx_type;
    ifsl_rx_type rx_st_ff;
    logic [3:0] rx_cnt_ff;
    logic [DATA_W-1:0] rx_sh_ff;
    logic rx_busy;
    assign rx_busy = (rx_st_ff == IFSL_SHIFT);
    always_ff @(posedge link_serial_clock) begin
        if (srst_s2_ff) begin
            rx_st_ff     <= IFSL_IDLE;
            rx_cnt_ff    <= 4'h0;
            rx_sh_ff     <= '0;
            rx_ev_tgl_ff <= 1'b0;
        end else if (!en_s2_ff) begin
            rx_st_ff     <= IFSL_IDLE;
            rx_cnt_ff    <= 4'h0;
            rx_sh_ff     <= '0;
            rx_ev_tgl_ff <= rx_ev_tgl_ff;
        end else begin
            unique case (rx_st_ff)
                IFSL_IDLE: begin
                    if (din_s2_ff == ifsl_pkg::START_LEVEL && rx_ev_tgl_ff == rxa_s2_ff) begin
                        rx_st_ff  <= IFSL_SHIFT;
                        rx_cnt_ff <= ifsl_pkg::BIT_FIRST_DATA;
                    end
                end
                IFSL_SHIFT: begin
                    rx_cnt_ff <= rx_cnt_ff + 4'h1;
                    if (rx_cnt_ff == ifsl_pkg::BIT_CHAN) begin
                        rx_chan_hold_ff <= din_s2_ff;
                        rx_hold_ff      <= rx_sh_ff;
                        rx_ev_tgl_ff    <= ~rx_ev_tgl_ff;
                        rx_st_ff        <= IFSL_WAIT;
                    end else begin
                        rx_sh_ff <= {din_s2_ff, rx_sh_ff[DATA_W-1:1]};
                    end
                end
                IFSL_WAIT: begin
                    if (rx_ev_tgl_ff == rxa_s2_ff) begin
                        rx_st_ff <= IFSL_IDLE;
                    end
                end
                default: rx_st_ff <= IFSL_IDLE;
            endcase
        end
    end
    always_ff @(posedge link_serial_clock) begin
        // Low from start bit until the delivered byte is consumed
        link_clear_to_send <= en_s2_ff && rx_st_ff == IFSL_IDLE
                              && din_s2_ff != ifsl_pkg::START_LEVEL
                              && rx_ev_tgl_ff == rxa_s2_ff;
    end

    // Link domain (falling edge): transmitter
    localparam int FRAME_BITS_W = ifsl_pkg::FRAME_BITS;
    logic [3:0] tx_cnt_ff;
    logic [FRAME_BITS_W-1:0] tx_sh_ff;
    logic tx_act_ff;
    always_ff @(negedge link_serial_clock) begin
        if (srst_s2_ff) begin
            tx_act_ff     <= 1'b0;
            tx_cnt_ff     <= 4'h0;
            tx_sh_ff      <= '1;
            tx_ack_tgl_ff <= 1'b0;
            link_data_out <= ifsl_pkg::LINE_IDLE;
        end else if (!en_s2_ff) begin
            // Held: a pending byte stays owed and goes out after release
            tx_act_ff     <= 1'b0;
            tx_cnt_ff     <= 4'h0;
            tx_sh_ff      <= '1;
            link_data_out <= ifsl_pkg::LINE_IDLE;
        end else if (!tx_act_ff) begin
            link_data_out <= ifsl_pkg::LINE_IDLE;
            if (txr_s2_ff != tx_ack_tgl_ff && !rx_busy && rx_st_ff == IFSL_IDLE
                && din_s2_ff != ifsl_pkg::START_LEVEL) begin
                tx_act_ff     <= 1'b1;
                link_data_out <= ifsl_pkg::START_LEVEL;
                tx_sh_ff      <= {ifsl_pkg::LINE_IDLE, tx_chan_hold_ff, tx_hold_ff};
                tx_cnt_ff     <= 4'h0;
            end
        end else begin
            link_data_out <= tx_sh_ff[0];
            tx_sh_ff      <= {1'b1, tx_sh_ff[FRAME_BITS_W-1:1]};
            tx_cnt_ff     <= tx_cnt_ff + 4'h1;
            if (tx_cnt_ff == ifsl_pkg::BIT_CHAN - 4'h1) begin
                tx_act_ff     <= 1'b0;
                tx_ack_tgl_ff <= ~tx_ack_tgl_ff;
            end
        end
    end

    // Checks
    a_rx_hold: assert property (@(posedge core_clk) disable iff (srst)
        (rx_valid && !rx_ready) |=> (rx_valid && $stable(rx_data) && $stable(rx_chan)))
        else $error("rx byte lost before accept");
    a_tx_chan_bit: assert property (@(negedge link_serial_clock)
        disable iff (!en_s2_ff)
        (tx_act_ff && tx_cnt_ff == ifsl_pkg::BIT_CHAN - 4'h1) |=> link_data_out == tx_chan_hold_ff)
        else $error("source channel bit wrong");
    a_tx_held_off: assert property (@(negedge link_serial_clock)
        !en_s2_ff |=> link_data_out)
        else $error("line driven while held");
    a_rx_first_bit: assert property (@(posedge link_serial_clock)
        disable iff (!en_s2_ff)
        (rx_st_ff == IFSL_IDLE && din_s2_ff == ifsl_pkg::START_LEVEL && rx_ev_tgl_ff == rxa_s2_ff)
        |=> (rx_st_ff == IFSL_SHIFT && rx_cnt_ff == ifsl_pkg::BIT_FIRST_DATA))
        else $error("rx did not start on start bit");

    a_cts_drop: assert property (@(posedge link_serial_clock)
        disable iff (!en_s2_ff)
        (rx_st_ff == IFSL_IDLE && din_s2_ff == 1'b0) |=> !link_clear_to_send)
        else $error("cts not dropped after start bit");
    a_cts_low_busy: assert property (@(posedge link_serial_clock)
        disable iff (!en_s2_ff)
        rx_busy |=> !link_clear_to_send)
        else $error("cts high during frame");
    a_tx_start: assert property (@(negedge link_serial_clock)
        disable iff (!en_s2_ff)
        $rose(tx_act_ff) |-> link_data_out == 1'b0)
        else $error("start bit not zero");
    a_tx_no_rx: assert property (@(negedge link_serial_clock)
        disable iff (!en_s2_ff)
        $rose(tx_act_ff) |-> !rx_busy)
        else $error("tx began during rx");
    a_tx_len: assert property (@(negedge link_serial_clock)
        disable iff (!en_s2_ff)
        $rose(tx_act_ff) |-> tx_act_ff [*8] ##1 tx_act_ff ##1 !tx_act_ff)
        else $error("frame length wrong");
    a_tx_idle: assert property (@(negedge link_serial_clock)
        disable iff (!en_s2_ff)
        (!tx_act_ff && !$fell(tx_act_ff)) |-> link_data_out)
        else $error("line not idle high");
    a_rx_len: assert property (@(posedge link_serial_clock)
        disable iff (!en_s2_ff)
        (rx_st_ff == IFSL_IDLE ##1 rx_st_ff == IFSL_SHIFT)
        |-> rx_busy [*8] ##1 rx_busy ##1 !rx_busy)
        else $error("rx frame length wrong");
    a_enable_cfg: assert property (@(posedge core_clk) disable iff (srst)
        !cfg_ok |=> !enable_ff)
        else $error("enabled without config");
    a_hold_mode: assert property (@(posedge core_clk) disable iff (srst)
        (bit_mode_load && bit_mode == ifsl_pkg::BMODE_HOLD) |=> ##1 !enable_ff)
        else $error("hold did not disable link");
    a_route_chan: assert property (@(posedge core_clk) disable iff (srst)
        rx_valid |-> (rx_chan ? cfg_chan_b_serial : cfg_chan_a_serial))
        else $error("byte routed to unconfigured channel");
    c_tx_frame: cover property (@(negedge link_serial_clock) $rose(tx_act_ff));
    c_rx_frame: cover property (@(posedge core_clk) $rose(rx_valid));
    c_rx_redirect: cover property (@(posedge core_clk) rx_valid && !cfg_chan_a_serial);
    c_rx_wait: cover property (@(posedge link_serial_clock) rx_st_ff == IFSL_WAIT);
    c_hold_release: cover property (@(posedge core_clk) $fell(hold_ff));
endmodule
`default_nettype wire

/* sim/ifsl_target.sv */
// Link target model: makes the link clock, sends and captures frames
`timescale 1ns/1ns
`default_nettype none
module ifsl_target (
    input  wire logic       run,
    input  wire logic       slow,
    input  wire logic       send_go,
    input  wire logic [7:0] send_byte,
    input  wire logic       send_destination_channel_bit,
    input  wire logic       link_data_out,
    input  wire logic       link_clear_to_send,
    output logic            link_serial_clock,
    output logic            link_data_in,
    output logic            send_busy,
    output logic [8:0]      got_frame,
    output int              got_count
);
    logic       pause;
    logic [9:0] shift;
    logic [9:0] fr;
    int         rcnt;

    // Clock runs only while asked to, parked low when run drops, stopped high during a slow pause
    always begin
        #16;
        if ((run || link_serial_clock) && !pause)
            link_serial_clock = ~link_serial_clock;
    end

    // Capture of outgoing frames on rising edges
    always @(posedge link_serial_clock) begin
        if (rcnt == 0) begin
            if (link_data_out === 1'b0) begin
                rcnt = 1;
                if (slow) begin
                    pause = 1'b1;
                    #640 pause = 1'b0;
                end
            end
        end else begin
            shift = {link_data_out, shift[9:1]};
            rcnt = rcnt + 1;
            if (rcnt == 10) begin
                got_frame = shift[9:1];
                got_count = got_count + 1;
                rcnt = 0;
            end
        end
    end

    // Incoming frames, driven after falling edges, idle high
    initial begin
        link_serial_clock = 1'b0;
        link_data_in = 1'b1;
        send_busy = 1'b0;
        pause = 1'b0;
        rcnt = 0;
        got_count = 0;
        got_frame = 9'h000;
        forever begin
            @(negedge link_serial_clock);
            if (send_go && link_clear_to_send === 1'b1) begin
                send_busy = 1'b1;
                fr = {send_destination_channel_bit, send_byte, 1'b0};
                for (int i = 0; i < 10; i++) begin
                    link_data_in = fr[i];
                    @(negedge link_serial_clock);
                end
                link_data_in = 1'b1;
                send_busy = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* sim/isolated_fast_serial_link_bench.sv */
// Bench for the serial link device end
`timescale 1ns/1ns
`default_nettype none
module isolated_fast_serial_link_bench;
    logic        core_clk, srst, cfg_a, cfg_b, bit_mode_load, tx_valid, tx_chan, tx_ready;
    logic        rx_valid, rx_chan, rx_ready, link_enabled, sclk, dout, din, cts;
    logic        run, slow, send_go, send_destination_channel_bit, send_busy;
    logic [3:0]  bit_mode;
    logic [7:0]  tx_data, rx_data, send_byte;
    logic [8:0]  got_frame;
    logic [31:0] seed;
    int          got_count, fail_count, check_count, n0;

    ifsl_link i_ifsl_link (.core_clk(core_clk), .srst(srst), .cfg_chan_a_serial(cfg_a),
        .cfg_chan_b_serial(cfg_b), .bit_mode(bit_mode), .bit_mode_load(bit_mode_load),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_chan(tx_chan), .tx_ready(tx_ready),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_chan(rx_chan), .rx_ready(rx_ready),
        .link_enabled(link_enabled), .link_serial_clock(sclk), .link_data_out(dout),
        .link_data_in(din), .link_clear_to_send(cts));
    ifsl_target i_ifsl_target (.run(run), .slow(slow), .send_go(send_go),
        .send_byte(send_byte), .send_destination_channel_bit(send_destination_channel_bit), .link_data_out(dout),
        .link_clear_to_send(cts), .link_serial_clock(sclk), .link_data_in(din),
        .send_busy(send_busy), .got_frame(got_frame), .got_count(got_count));

    always #20 core_clk = ~core_clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic exp_chan(input logic d, input logic a, input logic b);
        return d ? b : ~a;
    endfunction

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wait_sig(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 3000) begin
            @(negedge core_clk);
            n++;
        end
        check({15'h0, s}, {15'h0, v}, "wait");
    endtask

    task automatic load_mode(input logic [3:0] m);
        bit_mode = m;
        bit_mode_load = 1'b1;
        @(negedge core_clk);
        bit_mode_load = 1'b0;
        repeat (30) @(negedge core_clk);
    endtask

    task automatic push_tx(input logic [7:0] d, input logic c);
        tx_data = d;
        tx_chan = c;
        tx_valid = 1'b1;
        wait_sig(tx_ready, 1'b1);
        @(negedge core_clk);
        tx_valid = 1'b0;
        n0 = got_count;
    endtask

    task automatic wait_frame(input logic [7:0] d, input logic c);
        int n;
        n = 0;
        while (got_count == n0 && n < 3000) begin
            @(negedge core_clk);
            n++;
        end
        check(16'(got_count - n0), 16'h1, "tx count");
        check({7'h0, got_frame}, {7'h0, c, d}, "tx frame");
    endtask

    task automatic rx_case(input logic [7:0] d, input logic c);
        send_byte = d;
        send_destination_channel_bit = c;
        send_go = 1'b1;
        wait_sig(send_busy, 1'b1);
        send_go = 1'b0;
        wait_sig(rx_valid, 1'b1);
        check({15'h0, cts}, 16'h0, "cts held");
        check({7'h0, rx_chan, rx_data}, {7'h0, exp_chan(c, cfg_a, cfg_b), d}, "rx");
        rx_ready = 1'b1;
        @(negedge core_clk);
        rx_ready = 1'b0;
        wait_sig(cts, 1'b1);
        wait_sig(send_busy, 1'b0);
    endtask

    initial begin
        #1000000;
        fail_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        stop_test();
    end

    initial begin
        {core_clk, bit_mode_load, tx_valid, tx_chan, rx_ready, run, slow, send_go} = 8'h04;
        {cfg_a, cfg_b, srst} = 3'h7;
        {bit_mode, tx_data, send_byte, send_destination_channel_bit} = 21'h0;
        seed = 32'h000132ee;
        fail_count = 0;
        check_count = 0;
        repeat (20) @(negedge core_clk);
        srst = 1'b0;
        run = 1'b1;
        repeat (30) @(negedge core_clk);
        check({14'h0, link_enabled, cts}, 16'h3, "enabled");
        check({15'h0, dout}, 16'h1, "idle");
        push_tx(8'h00, 1'b0);
        wait_frame(8'h00, 1'b0);
        slow = 1'b1;
        push_tx(8'hff, 1'b1);
        wait_frame(8'hff, 1'b1);
        slow = 1'b0;
        for (int k = 0; k < 3; k++) begin
            cfg_a = (k != 1);
            cfg_b = (k != 2);
            repeat (30) @(negedge core_clk);
            for (int i = 0; i < 4; i++) begin
                seed = xs(seed);
                rx_case(seed[7:0], seed[8]);
                push_tx(seed[15:8], (k == 0) ? seed[16] : (k == 1));
                wait_frame(seed[15:8], (k == 0) ? seed[16] : (k == 1));
            end
        end
        load_mode(ifsl_pkg::BMODE_HOLD);
        check({15'h0, link_enabled}, 16'h0, "held");
        push_tx(8'h5a, 1'b1);
        repeat (200) @(negedge core_clk);
        check(16'(got_count - n0), 16'h0, "held silent");
        load_mode(ifsl_pkg::BMODE_RUN);
        wait_frame(8'h5a, 1'b1);
        {cfg_a, cfg_b} = 2'h0;
        repeat (30) @(negedge core_clk);
        check({14'h0, link_enabled, tx_ready}, 16'h0, "disabled");
        stop_test();
    end
endmodule
`default_nettype wire
